// ### dv/bmcsr_tb.sv
// Purpose: self-checking bench for the compare-swap and bus-info register bank
// Assumes: APB3 master tasks, one clock, no separate partner model
// Notes: resource reset values follow the package constants
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] rom_header_out;
  logic [31:0] bus_options_out;
  int          err_count;
  int          check_count;
  int          cycles;
  logic [31:0] rv;
  logic        re;
  logic [31:0] old_v;
  logic [31:0] new_v;
  logic [31:0] res_init [4];

  bmcsr_regs uut (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .irq             (irq),
    .rom_header_out  (rom_header_out),
    .bus_options_out (bus_options_out)
  );

  initial begin
    pclk = 1'b0;
  end
  always #25 pclk = ~pclk;

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // bench-wide ceiling well above the expected few hundred cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  // master holds every request signal until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    end
    rv = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic swap(input logic [31:0] c, input logic [31:0] d, input logic [31:0] ctl);
    wr(bmcsr_pkg::OFS_SWAP_CMP, c);
    wr(bmcsr_pkg::OFS_SWAP_DATA, d);
    wr(bmcsr_pkg::OFS_SWAP_CTRL, ctl);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    err_count = 0;
    check_count = 0;
    cycles = 0;
    res_init = '{bmcsr_pkg::RES_BM_ID_RESET, bmcsr_pkg::RES_BW_RESET,
                 bmcsr_pkg::RES_CH_RESET, bmcsr_pkg::RES_CH_RESET};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(bmcsr_pkg::OFS_SWAP_CTRL);   `CHK(rv, 32'h8000_0000)
    rd(bmcsr_pkg::OFS_ROM_HDR);     `CHK(rv, 32'h0000_0000)
    rd(bmcsr_pkg::OFS_BUS_OPT);     `CHK(rv, 32'h0000_B003)
    `CHK(bus_options_out, 32'h0000_B003)
    wr(bmcsr_pkg::OFS_BUS_ID, 32'h0000_0000);
    rd(bmcsr_pkg::OFS_BUS_ID);      `CHK(rv, 32'h3133_3934)
    wr(bmcsr_pkg::OFS_ROM_HDR, 32'hA5C3_1234);
    rd(bmcsr_pkg::OFS_ROM_HDR);     `CHK(rv, 32'hA5C3_1234)
    `CHK(rom_header_out, 32'hA5C3_1234)
    wr(bmcsr_pkg::OFS_BUS_OPT, 32'hFFFF_0000);
    rd(bmcsr_pkg::OFS_BUS_OPT);     `CHK(rv, 32'hF8FF_B003)
    #1;
    `CHK(bus_options_out, 32'hF8FF_B003)
    rd(12'h040);                    `CHK({re, rv}, {1'b1, 32'h0000_0000})
    rd(bmcsr_pkg::OFS_IRQ_CLEAR);   `CHK({re, rv}, {1'b0, 32'h0000_0000})
    // only the match event is enabled, so a mismatch must stay silent
    wr(bmcsr_pkg::OFS_IRQ_ENABLE, 32'h0000_0001);
    for (int s = 0; s < 4; s++) begin
      old_v = res_init[s];
      new_v = 32'h5A5A_0F00 | 32'(s);
      swap(~old_v, new_v, 32'h7FFF_FFFC | 32'(s));
      rd(bmcsr_pkg::OFS_SWAP_CTRL); `CHK(rv, 32'h8000_0000 | 32'(s))
      rd(bmcsr_pkg::OFS_SWAP_DATA); `CHK(rv, old_v)
      rd(bmcsr_pkg::OFS_IRQ_STATUS); `CHK(rv, 32'h0000_0002)
      `CHK(irq, 1'b0)
      swap(old_v, new_v, 32'(s));
      rd(bmcsr_pkg::OFS_SWAP_DATA); `CHK(rv, old_v)
      rd(bmcsr_pkg::OFS_SWAP_CTRL); `CHK(rv, 32'h8000_0000 | 32'(s))
      rd(bmcsr_pkg::OFS_IRQ_STATUS); `CHK(rv, 32'h0000_0003)
      `CHK(irq, 1'b1)
      wr(bmcsr_pkg::OFS_IRQ_CLEAR, 32'h0000_0003);
      settle();
      `CHK(irq, 1'b0)
      // swapping back proves the resource really took the new value
      swap(new_v, old_v, 32'(s));
      rd(bmcsr_pkg::OFS_SWAP_DATA); `CHK(rv, new_v)
      wr(bmcsr_pkg::OFS_IRQ_CLEAR, 32'h0000_0003);
    end
    test_done();
  end
endmodule
`default_nettype wire

// ### rtl/bmcsr_pkg.sv
// Purpose: constants of the bus-management compare-swap and bus-info register bank
// Assumes: APB3 slave, 32-bit data, byte addresses equal to the printed offsets
// Notes: Operation list below summarises the design
// Operation
// - compare register holds value checked against resource
// - swap data supplies new resource value
// - done flag bit 31 set on completion
// - control write clears done until completion
// - selector bits 1-0 pick four resources
// - control bits 30-2 read zero
// - control resets with done flag set
// - rom header is first config rom quadlet
// - info length bits 31-24 writable, reset zero
// - crc length bits 23-16 writable, reset zero
// - bus identification reads fixed constant only
// - bus options mixes writable and read-only fields
// - bus options resets to upper zero, lower pattern
// - bus options bits 31-27 writable, reset zero
`default_nettype none
package bmcsr_pkg;
  localparam int unsigned APB_AW = 12;
  localparam logic [11:0] OFS_SWAP_DATA   = 12'h00C;
  localparam logic [11:0] OFS_SWAP_CMP    = 12'h010;
  localparam logic [11:0] OFS_SWAP_CTRL   = 12'h014;
  localparam logic [11:0] OFS_ROM_HDR     = 12'h018;
  localparam logic [11:0] OFS_BUS_ID      = 12'h01C;
  localparam logic [11:0] OFS_BUS_OPT     = 12'h020;
  localparam logic [11:0] OFS_IRQ_STATUS  = 12'h024;
  localparam logic [11:0] OFS_IRQ_CLEAR   = 12'h028;
  localparam logic [11:0] OFS_IRQ_ENABLE  = 12'h02C;
  localparam int unsigned DONE_BIT        = 31;
  localparam logic        CTRL_DONE_RESET = 1'b1;
  localparam logic [1:0]  CTRL_SEL_RESET  = 2'h0;
  localparam logic [31:0] ROM_HDR_RESET   = 32'h0000_0000;
  localparam logic [31:0] BUS_ID_VALUE    = 32'h3133_3934;
  localparam logic [15:0] BUS_OPT_LOW     = 16'hB003;
  localparam logic [31:0] BUS_OPT_WMASK   = 32'hF8FF_0000;
  localparam logic [31:0] BUS_OPT_RESET   = 32'h0000_0000;
  localparam logic [31:0] RES_BM_ID_RESET = 32'h0000_003F;
  localparam logic [31:0] RES_BW_RESET    = 32'h0000_1333;
  localparam logic [31:0] RES_CH_RESET    = 32'hFFFF_FFFF;
  localparam logic [31:0] SWAP_REG_RESET  = 32'h0000_0000;
  localparam int unsigned IRQ_W           = 2;
  localparam int unsigned IRQ_SWAP_OK     = 0;
  localparam int unsigned IRQ_SWAP_FAIL   = 1;
  typedef enum logic [1:0] {
    BMCSR_SEL_BM_ID   = 2'b00,
    BMCSR_SEL_BW      = 2'b01,
    BMCSR_SEL_CH_HI   = 2'b10,
    BMCSR_SEL_CH_LO   = 2'b11
  } bmcsr_sel_e;
  typedef enum logic {
    BMCSR_IDLE = 1'b0,
    BMCSR_SWAP = 1'b1
  } bmcsr_state_e;
endpackage
`default_nettype wire

// ### rtl/bmcsr_regs.sv
// Purpose: compare-swap access to bus-management resources plus bus-info quadlets
// Assumes: APB3 master, one wait state per access, inputs synchronous to pclk
// Notes: swap data register returns the old resource value after each swap
`default_nettype none
module bmcsr_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic      [31:0] rom_header_out,
  output logic      [31:0] bus_options_out
);

  // access phase ends on the edge where our registered pready is high
  wire        acc      = psel & penable & pready;
  wire        wr       = acc & pwrite;
  wire        prep     = psel & penable & ~pready;
  wire        hit_data = (paddr == bmcsr_pkg::OFS_SWAP_DATA);
  wire        hit_cmp  = (paddr == bmcsr_pkg::OFS_SWAP_CMP);
  wire        hit_ctrl = (paddr == bmcsr_pkg::OFS_SWAP_CTRL);
  wire        hit_rom  = (paddr == bmcsr_pkg::OFS_ROM_HDR);
  wire        hit_bid  = (paddr == bmcsr_pkg::OFS_BUS_ID);
  wire        hit_bo   = (paddr == bmcsr_pkg::OFS_BUS_OPT);
  wire        hit_ist  = (paddr == bmcsr_pkg::OFS_IRQ_STATUS);
  wire        hit_icl  = (paddr == bmcsr_pkg::OFS_IRQ_CLEAR);
  wire        hit_ien  = (paddr == bmcsr_pkg::OFS_IRQ_ENABLE);
  wire        hit_any  = hit_data | hit_cmp | hit_ctrl | hit_rom | hit_bid | hit_bo | hit_ist | hit_icl | hit_ien;
  wire        wr_data  = wr & hit_data;
  wire        wr_cmp   = wr & hit_cmp;
  wire        wr_ctrl  = wr & hit_ctrl;
  wire        wr_rom   = wr & hit_rom;
  wire        wr_bo    = wr & hit_bo;
  wire        wr_icl   = wr & hit_icl;
  wire        wr_ien   = wr & hit_ien;

  logic [31:0]             swap_data;
  logic [31:0]             swap_compare_value;
  logic                    swap_done_flag;
  logic [1:0]              resource_selector;
  logic [31:0]             rom_header_quadlet;
  logic [31:0]             bus_options_wr;
  logic [31:0]             res_arr [4];
  logic [bmcsr_pkg::IRQ_W-1:0] irq_status;
  logic [bmcsr_pkg::IRQ_W-1:0] irq_enable;
  bmcsr_pkg::bmcsr_state_e state;
  bmcsr_pkg::bmcsr_state_e next_state;

  wire [31:0] res_cur   = res_arr[resource_selector];
  wire        swap_hit  = (state == bmcsr_pkg::BMCSR_SWAP);
  wire        swap_eq   = (res_cur == swap_compare_value);
  wire        swap_ok   = swap_hit & swap_eq;
  wire        swap_fail = swap_hit & ~swap_eq;
  // reserved bits come from constant zero, not from storage
  wire [31:0] ctrl_rd   = {swap_done_flag, 29'h0000_0000, resource_selector};
  // read-only fields come from the constant, so a stray write cannot reach them
  wire [31:0] bo_rd     = (bus_options_wr & bmcsr_pkg::BUS_OPT_WMASK) |
                          {16'h0000, bmcsr_pkg::BUS_OPT_LOW};
  wire [31:0] ist_rd    = {{(32-bmcsr_pkg::IRQ_W){1'b0}}, irq_status};
  wire [31:0] ien_rd    = {{(32-bmcsr_pkg::IRQ_W){1'b0}}, irq_enable};
  wire [bmcsr_pkg::IRQ_W-1:0] irq_set = {swap_fail, swap_ok};
  wire [bmcsr_pkg::IRQ_W-1:0] irq_clr = wr_icl ? pwdata[bmcsr_pkg::IRQ_W-1:0] : {bmcsr_pkg::IRQ_W{1'b0}};
  // set beats clear so a completion during a clear write is kept
  wire [bmcsr_pkg::IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_set;

  wire [31:0] rd_mux =
      hit_data ? swap_data :
      hit_cmp  ? swap_compare_value :
      hit_ctrl ? ctrl_rd :
      hit_rom  ? rom_header_quadlet :
      hit_bid  ? bmcsr_pkg::BUS_ID_VALUE :
      hit_bo   ? bo_rd :
      hit_ist  ? ist_rd :
      hit_ien  ? ien_rd :
      32'h0000_0000;

  // one wait state keeps pready and prdata straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= prep;
      pslverr <= prep & ~hit_any;
      if (prep && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // compare-swap sequencer: one cycle to compare and update
  always_comb begin
    next_state = state;
    unique case (state)
      bmcsr_pkg::BMCSR_IDLE: if (wr_ctrl) next_state = bmcsr_pkg::BMCSR_SWAP;
      bmcsr_pkg::BMCSR_SWAP: next_state = bmcsr_pkg::BMCSR_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= bmcsr_pkg::BMCSR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_done_flag    <= bmcsr_pkg::CTRL_DONE_RESET;
      resource_selector <= bmcsr_pkg::CTRL_SEL_RESET;
    end else if (wr_ctrl) begin
      swap_done_flag    <= 1'b0;
      resource_selector <= pwdata[1:0];
    end else if (swap_hit) begin
      swap_done_flag    <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_compare_value <= bmcsr_pkg::SWAP_REG_RESET;
    end else if (wr_cmp) begin
      swap_compare_value <= pwdata;
    end
  end

  // data register returns the old resource value so software sees the result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_data <= bmcsr_pkg::SWAP_REG_RESET;
    end else if (swap_hit) begin
      swap_data <= res_cur;
    end else if (wr_data) begin
      swap_data <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_arr[bmcsr_pkg::BMCSR_SEL_BM_ID] <= bmcsr_pkg::RES_BM_ID_RESET;
      res_arr[bmcsr_pkg::BMCSR_SEL_BW]    <= bmcsr_pkg::RES_BW_RESET;
      res_arr[bmcsr_pkg::BMCSR_SEL_CH_HI] <= bmcsr_pkg::RES_CH_RESET;
      res_arr[bmcsr_pkg::BMCSR_SEL_CH_LO] <= bmcsr_pkg::RES_CH_RESET;
    end else if (swap_ok) begin
      res_arr[resource_selector] <= swap_data;
    end
  end

  // no lock against link enable: validity while linked is up to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_header_quadlet <= bmcsr_pkg::ROM_HDR_RESET;
    end else if (wr_rom) begin
      rom_header_quadlet <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_options_wr <= bmcsr_pkg::BUS_OPT_RESET;
    end else if (wr_bo) begin
      bus_options_wr <= pwdata & bmcsr_pkg::BUS_OPT_WMASK;
    end
  end

  // quadlets facing the serial bus side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_header_out  <= bmcsr_pkg::ROM_HDR_RESET;
      bus_options_out <= {16'h0000, bmcsr_pkg::BUS_OPT_LOW};
    end else begin
      rom_header_out  <= rom_header_quadlet;
      bus_options_out <= bo_rd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= {bmcsr_pkg::IRQ_W{1'b0}};
      irq_enable <= {bmcsr_pkg::IRQ_W{1'b0}};
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_ien) begin
        irq_enable <= pwdata[bmcsr_pkg::IRQ_W-1:0];
      end
      irq <= |(next_irq_status & (wr_ien ? pwdata[bmcsr_pkg::IRQ_W-1:0] : irq_enable));
    end
  end

  AST_SWAP_TAKES: assert property (@(posedge pclk) disable iff (!presetn)
    swap_ok |=> res_arr[$past(resource_selector)] == $past(swap_data))
    else $error("matching swap did not store the swap data");

  AST_SWAP_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
    swap_fail |=> res_arr[$past(resource_selector)] == $past(res_cur))
    else $error("mismatching swap changed the resource");

  AST_OLD_RETURNED: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> ##1 swap_data == $past(res_arr[pwdata[1:0]], 2))
    else $error("swap data does not show the old resource value");

  AST_DONE_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> !swap_done_flag)
    else $error("done flag not cleared by control write");

  AST_DONE_SETS: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> !swap_done_flag ##1 swap_done_flag)
    else $error("done flag not set one cycle after the launch");

  AST_CTRL_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
    prep && !pwrite && hit_ctrl |=> prdata[30:2] == 29'h0000_0000)
    else $error("control reserved bits read nonzero");

  AST_SEL_PICK: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> resource_selector == $past(pwdata[1:0]))
    else $error("selector not taken from the control write");

  AST_BUS_ID: assert property (@(posedge pclk) disable iff (!presetn)
    prep && !pwrite && hit_bid |=> prdata == bmcsr_pkg::BUS_ID_VALUE && pready)
    else $error("bus identification read wrong");

  AST_ROM_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_rom |=> ##1 rom_header_out == $past(pwdata, 2))
    else $error("rom header write not reflected");

  AST_BUS_OPT: assert property (@(posedge pclk) disable iff (!presetn)
    wr_bo |=> ##1 bus_options_out ==
      (($past(pwdata, 2) & bmcsr_pkg::BUS_OPT_WMASK) | {16'h0000, bmcsr_pkg::BUS_OPT_LOW}))
    else $error("bus options write or fixed fields wrong");

  AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    swap_ok && irq_enable[bmcsr_pkg::IRQ_SWAP_OK] && !wr_ien |=> irq)
    else $error("enabled completion did not raise irq");

  AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready stood longer than one cycle");

  AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    prep && !hit_any |=> pready && pslverr)
    else $error("unmapped access did not report an error");

  AST_CMP_TAKES: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmp |=> swap_compare_value == $past(pwdata))
    else $error("compare register did not take the written value");

  // done flag may only move on a control write or on the swap cycle
  AST_DONE_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_ctrl && !swap_hit |=> swap_done_flag == $past(swap_done_flag))
    else $error("done flag changed without a write or a swap");

  AST_BO_FIXED: assert property (@(posedge pclk) disable iff (!presetn)
    bus_options_out[26:24] == 3'h0 && bus_options_out[15:0] == bmcsr_pkg::BUS_OPT_LOW)
    else $error("bus options read-only fields wrong");

  AST_IRQ_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    wr_icl && !swap_hit && pwdata[1:0] == 2'h3 |=> !irq)
    else $error("irq stayed high after clearing every status bit");

  COV_SWAP_OK:   cover property (@(posedge pclk) disable iff (!presetn) swap_ok);
  COV_SWAP_FAIL: cover property (@(posedge pclk) disable iff (!presetn) swap_fail);
  COV_IRQ:       cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  COV_ERR:       cover property (@(posedge pclk) disable iff (!presetn) pslverr && pready);

endmodule
`default_nettype wire
